// ==== include/sfr_params.svh ====
// Constants of the multi-line read sequencer: opcodes, phase lengths,
// reset values. Assumes inclusion by bare name from the modules; the package does not include it.
`ifndef SFR_PARAMS_SVH
`define SFR_PARAMS_SVH

`define SFR_OP_DUAL_IO 8'hbb
`define SFR_OP_QUAD_IO 8'heb
`define SFR_OP_WORD_IO 8'he7
`define SFR_SKIP_CODE 2'h2
`define SFR_OPC_LAST_SINGLE 5'h07
`define SFR_OPC_LAST_FOUR 5'h01
`define SFR_ADDR_LAST_DUAL 5'h0b
`define SFR_ADDR_LAST_QUAD 5'h05
`define SFR_MODE_LAST_DUAL 5'h03
`define SFR_MODE_LAST_QUAD 5'h01
`define SFR_DUMMY_DUAL 5'h00
`define SFR_DUMMY_QUAD_SINGLE 5'h04
`define SFR_DUMMY_WORD 5'h02
`define SFR_CHUNK_LAST_DUAL 5'h03
`define SFR_CHUNK_LAST_QUAD 5'h01
`define SFR_WRAP_RESET 3'h1
`define SFR_DUMMY_SEL_RESET 2'h0
`define SFR_ADDR_RESET 24'h00_0000
`define SFR_PAGE_BITS 8

`endif

// ==== include/sfr_pkg.sv ====
// Types shared by the multi-line read sequencer.
// Assumes sfr_params.svh is on the include path.
`default_nettype none

package sfr_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OPCODE,
        ST_ADDR,
        ST_MODE,
        ST_DUMMY,
        ST_DATA,
        ST_IGNORE
    } sfr_state_t;

    typedef enum logic [1:0] {
        K_DUAL,
        K_QUAD,
        K_WORD
    } sfr_kind_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic [3:0] io;
    } sfr_link_t;

    typedef struct packed {
        sfr_state_t st;
        sfr_kind_t kind;
        logic [23:0] sh;
        logic [4:0] cnt;
        logic [23:0] addr;
        logic skip;
        sfr_kind_t skip_kind;
        logic [2:0] wrap;
        logic [1:0] dummy_sel;
        logic sclk_d;
        logic [3:0] io_out;
        logic [3:0] io_oe;
        logic [23:0] mem_addr;
        logic active;
    } sfr_regs_t;

endpackage

`default_nettype wire

// ==== hdl/sfr_sync.sv ====
// Two-flop synchroniser for pins from the host side.
// Assumes inputs are asynchronous to sys_clk; only q may be read.
`default_nettype none

module sfr_sync #(
    parameter int W = 6,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    if (W < 1) begin : g_bad_width
        $error("sfr_sync: width must be positive");
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

`default_nettype wire

// ==== hdl/sfr_addr_step.sv ====
// Next read address: linear or wrapped inside a page section.
// Purely combinational; caller registers the result.
`default_nettype none
`include "sfr_params.svh"

module sfr_addr_step (
    input wire logic [23:0] addr,
    input wire logic wrap_on,
    input wire logic [1:0] len_sel,
    output logic [23:0] next
);
    logic [7:0] mask;
    logic [7:0] inc;

    always_comb begin
        // Section of 8, 16, 32 or 64 bytes
        mask = 8'((8'h08 << len_sel) - 8'h01);
        inc = 8'(addr[7:0] + 8'h01);
        if (wrap_on) begin
            next = {addr[23:`SFR_PAGE_BITS],
                    (addr[7:0] & ~mask) | (inc & mask)};
        end else begin
            next = 24'(addr + 24'h00_0001);
        end
    end
endmodule

`default_nettype wire

// ==== hdl/sfr_multi_io_read.sv ====
// Multi-line random-access read sequencer of a serial flash.
// Assumes the host link pins are asynchronous; array data on mem_rdata
// follows mem_addr within two sys_clk cycles.
//
// Functional notes
// RULE1: Dual read address two bits per clock.
// RULE2: Mode byte after address; upper nibble counts.
// RULE3: Dual skip bits 10: next frame starts address.
// RULE4: Other skip value: next frame needs opcode.
// RULE5: Host exits dual skip with sixteen ones.
// RULE6: Host exits quad skip with eight ones.
// RULE7: Host releases lines before first data edge.
// RULE8: Quad read four lines, four dummies single-line.
// RULE9: Quad opcodes only when quad lines enabled.
// RULE10: Quad skip condition drops next opcode.
// RULE11: Wrap within section until chip select rises.
// RULE12: Wrap setting governs following quad reads.
// RULE13: Three wrap bits: disable plus length.
// RULE14: Four-line dummies 2/4/6/8, default 2.
// RULE15: Skip and wrap also in four-line mode.
// RULE16: Word read even address, two dummies.
// RULE17: Word read skip drops next opcode.
// RULE18: Wrap setting governs following word reads.
// RULE19: Length 8/16/32/64; disable bit one at reset.
// RULE20: Four-line dummies from read parameter field.
// RULE21: Unwrapped reads stream sequential bytes.
// RULE22: Dummies ignored; drive only in data phase.
`default_nettype none
`include "sfr_params.svh"

module sfr_multi_io_read (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic sclk_pin,
    input wire logic cs_n_pin,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    input wire logic quad_lines_enable,
    input wire logic four_line_command_mode,
    input wire logic wrap_load,
    input wire logic [2:0] wrap_settings,
    input wire logic read_param_load,
    input wire logic [1:0] read_param_dummy,
    input wire logic reset_cmd,
    output logic [23:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    output logic skip_armed,
    output logic read_active,
    output logic [2:0] wrap_state
);
    import sfr_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    sfr_link_t link_raw;
    sfr_link_t lk;

    assign link_raw = '{sclk: sclk_pin, cs_n: cs_n_pin, io: io_in};

    sfr_sync #(
        .W(6),
        .RST_VAL(6'h10)
    ) u_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .d(link_raw),
        .q(lk)
    );

    ////////////////////////////////////////////////////////////////////
    // State and address stepping

    sfr_regs_t s_r;
    sfr_regs_t s_nxt;
    logic [23:0] addr_next;
    logic wrap_on;
    logic io_line_zero;

    assign io_line_zero = lk.io[0];
    // Wrapping applies to quad and word reads; dual reads stream linearly
    assign wrap_on = (s_r.kind != K_DUAL) && !s_r.wrap[0]; // RULE12 RULE18

    sfr_addr_step u_step (
        .addr(s_r.addr),
        .wrap_on(wrap_on),
        .len_sel(s_r.wrap[2:1]),
        .next(addr_next)
    );

    ////////////////////////////////////////////////////////////////////
    // Next-state logic

    logic rise;
    logic fall;
    logic [23:0] sh_in;
    logic [4:0] addr_last;
    logic [4:0] mode_last;
    logic [4:0] dummy_n;
    logic [4:0] chunk_last;
    logic [7:0] opc;

    always_comb begin
        s_nxt = s_r;
        rise = lk.sclk && !s_r.sclk_d;
        fall = !lk.sclk && s_r.sclk_d;
        s_nxt.sclk_d = lk.sclk;
        opc = 8'h00;

        // Address, mode and data lanes follow the read kind
        if (s_r.kind == K_DUAL) begin
            sh_in = {s_r.sh[21:0], lk.io[1:0]}; // RULE1
            addr_last = `SFR_ADDR_LAST_DUAL; // RULE1
            mode_last = `SFR_MODE_LAST_DUAL;
            chunk_last = `SFR_CHUNK_LAST_DUAL;
        end else begin
            sh_in = {s_r.sh[19:0], lk.io}; // RULE8
            addr_last = `SFR_ADDR_LAST_QUAD; // RULE8
            mode_last = `SFR_MODE_LAST_QUAD;
            chunk_last = `SFR_CHUNK_LAST_QUAD;
        end

        case (s_r.kind)
            K_DUAL: dummy_n = `SFR_DUMMY_DUAL;
            K_WORD: dummy_n = `SFR_DUMMY_WORD; // RULE16
            default: begin
                if (four_line_command_mode) begin
                    // 2, 4, 6 or 8 from the read parameter field
                    // Widened first: the top setting of 8 needs four bits
                    dummy_n = {2'h0, s_r.dummy_sel, 1'b0}
                        + 5'h02; // RULE14 RULE20
                end else begin
                    dummy_n = `SFR_DUMMY_QUAD_SINGLE; // RULE8
                end
            end
        endcase

        if (wrap_load) begin
            s_nxt.wrap = wrap_settings; // RULE12 RULE13 RULE18
        end
        if (reset_cmd) begin
            s_nxt.dummy_sel = `SFR_DUMMY_SEL_RESET; // RULE14
        end
        if (read_param_load) begin
            s_nxt.dummy_sel = read_param_dummy; // RULE20
        end

        if (lk.cs_n) begin
            // Frame end: release lines, section wrap stops here
            s_nxt.st = ST_IDLE; // RULE11
            s_nxt.io_oe = 4'h0;
            s_nxt.cnt = 5'h00;
        end else begin
            case (s_r.st)
                ST_IDLE: begin
                    s_nxt.cnt = 5'h00;
                    s_nxt.sh = `SFR_ADDR_RESET;
                    if (s_r.skip) begin
                        // Previous mode byte armed opcode skipping
                        s_nxt.kind = s_r.skip_kind; // RULE3 RULE10 RULE17
                        s_nxt.st = ST_ADDR; // RULE3 RULE10 RULE15 RULE17
                    end else begin
                        s_nxt.st = ST_OPCODE; // RULE4
                    end
                end
                ST_OPCODE: begin
                    if (rise) begin
                        if (four_line_command_mode) begin
                            s_nxt.sh = {s_r.sh[19:0], lk.io};
                        end else begin
                            s_nxt.sh = {s_r.sh[22:0], io_line_zero};
                        end
                        s_nxt.cnt = 5'(s_r.cnt + 5'h01);
                        opc = s_nxt.sh[7:0];
                        if (s_r.cnt == (four_line_command_mode ?
                                `SFR_OPC_LAST_FOUR : `SFR_OPC_LAST_SINGLE)) begin
                            s_nxt.cnt = 5'h00;
                            s_nxt.sh = `SFR_ADDR_RESET;
                            s_nxt.st = ST_ADDR;
                            if (opc == `SFR_OP_DUAL_IO
                                    && !four_line_command_mode) begin
                                s_nxt.kind = K_DUAL; // RULE1
                            end else if (opc == `SFR_OP_QUAD_IO
                                    && quad_lines_enable) begin
                                s_nxt.kind = K_QUAD; // RULE9
                            end else if (opc == `SFR_OP_WORD_IO
                                    && quad_lines_enable) begin
                                s_nxt.kind = K_WORD; // RULE9
                            end else begin
                                // Anything else is not this block's command
                                s_nxt.st = ST_IGNORE; // RULE9
                            end
                        end
                    end
                end
                ST_ADDR: begin
                    if (rise) begin
                        s_nxt.sh = sh_in;
                        s_nxt.cnt = 5'(s_r.cnt + 5'h01);
                        if (s_r.cnt == addr_last) begin
                            // Host keeps bit 0 clear for word reads
                            s_nxt.addr = sh_in; // RULE16
                            s_nxt.mem_addr = sh_in;
                            s_nxt.cnt = 5'h00;
                            s_nxt.st = ST_MODE;
                        end
                    end
                end
                ST_MODE: begin
                    if (rise) begin
                        s_nxt.sh = sh_in;
                        s_nxt.cnt = 5'(s_r.cnt + 5'h01);
                        if (s_r.cnt == mode_last) begin
                            // Only the skip pair of the upper nibble matters
                            s_nxt.skip =
                                (sh_in[5:4] == `SFR_SKIP_CODE); // RULE2 RULE3
                            s_nxt.skip_kind = s_r.kind; // RULE4 RULE10 RULE17
                            s_nxt.cnt = 5'h00;
                            s_nxt.st = (dummy_n == 5'h00) ? ST_DATA : ST_DUMMY;
                        end
                    end
                end
                ST_DUMMY: begin
                    // Line values are not looked at here
                    if (rise) begin
                        s_nxt.cnt = 5'(s_r.cnt + 5'h01); // RULE22
                        if (s_r.cnt == 5'(dummy_n - 5'h01)) begin
                            s_nxt.cnt = 5'h00;
                            s_nxt.st = ST_DATA; // RULE8 RULE14 RULE16
                        end
                    end
                end
                ST_DATA: begin
                    // Host has released the lines before this edge
                    if (fall) begin
                        if (s_r.kind == K_DUAL) begin
                            case (s_r.cnt[1:0])
                                2'h0: s_nxt.io_out = {2'h0, mem_rdata[7:6]};
                                2'h1: s_nxt.io_out = {2'h0, mem_rdata[5:4]};
                                2'h2: s_nxt.io_out = {2'h0, mem_rdata[3:2]};
                                default: s_nxt.io_out = {2'h0, mem_rdata[1:0]};
                            endcase
                            s_nxt.io_oe = 4'h3; // RULE7 RULE22
                        end else begin
                            s_nxt.io_out = s_r.cnt[0] ? mem_rdata[3:0]
                                                      : mem_rdata[7:4];
                            s_nxt.io_oe = 4'hf; // RULE8 RULE22
                        end
                        s_nxt.cnt = 5'(s_r.cnt + 5'h01);
                        if (s_r.cnt == chunk_last) begin
                            s_nxt.cnt = 5'h00;
                            s_nxt.addr = addr_next; // RULE11 RULE21
                            s_nxt.mem_addr = addr_next; // RULE11 RULE21
                        end
                    end
                end
                ST_IGNORE: begin
                    // Lines stay released until chip select rises
                    s_nxt.io_oe = 4'h0;
                end
                default: begin
                    s_nxt.st = ST_IGNORE;
                end
            endcase
        end
        s_nxt.active = (s_nxt.st == ST_DATA);
    end

    ////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s_r.st <= ST_IDLE;
            s_r.kind <= K_DUAL;
            s_r.sh <= `SFR_ADDR_RESET;
            s_r.cnt <= 5'h00;
            s_r.addr <= `SFR_ADDR_RESET;
            s_r.skip <= 1'b0;
            s_r.skip_kind <= K_DUAL;
            s_r.wrap <= `SFR_WRAP_RESET; // RULE19
            s_r.dummy_sel <= `SFR_DUMMY_SEL_RESET; // RULE14
            s_r.sclk_d <= 1'b0;
            s_r.io_out <= 4'h0;
            s_r.io_oe <= 4'h0;
            s_r.mem_addr <= `SFR_ADDR_RESET;
            s_r.active <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign io_out = s_r.io_out;
    assign io_oe = s_r.io_oe;
    assign mem_addr = s_r.mem_addr;
    assign skip_armed = s_r.skip;
    assign read_active = s_r.active;
    assign wrap_state = s_r.wrap;

endmodule

`default_nettype wire

// ==== sim/sfr_multi_io_read_monitor.sv ====
// Port checker for the multi-line read sequencer.
// Assumes one sys_clk domain; bound below onto the design top.
`default_nettype none

module sfr_chk (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic cs_n_pin,
    input wire logic [3:0] io_oe,
    input wire logic quad_lines_enable,
    input wire logic wrap_load,
    input wire logic [2:0] wrap_settings,
    input wire logic [23:0] mem_addr,
    input wire logic skip_armed,
    input wire logic read_active,
    input wire logic [2:0] wrap_state
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] pa_r;
    logic step;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    always_ff @(posedge sys_clk) pa_r <= mem_addr;
    assign step = read_active && mem_addr != pa_r;
    ////////////////////////////////////////////////////////////////////
    AST_WRAP_LOAD: assert property (wrap_load |=>
        wrap_state == $past(wrap_settings)) else $error("wrap not loaded");
    AST_WRAP_HOLD: assert property (!wrap_load |=>
        $stable(wrap_state)) else $error("wrap changed unasked");
    AST_DRIVE_DATA: assert property ($rose(|io_oe) |->
        read_active) else $error("drive outside data phase");
    AST_LINES: assert property (io_oe != 4'h0 |->
        io_oe == 4'h3 || io_oe == 4'hf) else $error("bad line set");
    AST_CS_OFF: assert property ($rose(cs_n_pin) |->
        ##[1:6] io_oe == 4'h0) else $error("drive after deselect");
    AST_QUAD_GATE: assert property ($rose(io_oe == 4'hf) |->
        quad_lines_enable) else $error("quad without enable");
    AST_SKIP_HOLD: assert property ($changed(skip_armed) |->
        !cs_n_pin) else $error("skip changed between frames");
    AST_LINEAR: assert property (step && wrap_state[0] |->
        mem_addr == pa_r + 24'h1) else $error("linear step wrong");
    AST_SECTION: assert property (step && !wrap_state[0] |->
        ((mem_addr ^ pa_r) & {16'hffff, 8'hf8 << wrap_state[2:1]})
        == 24'h0) else $error("left wrap section");
    COV_WRAP: cover property (step && !wrap_state[0]);
    COV_SKIP: cover property ($rose(skip_armed));
    COV_QUAD: cover property ($rose(io_oe == 4'hf));
endmodule

bind sfr_multi_io_read sfr_chk u_sfr_chk (
    .sys_clk(sys_clk), .rstn(rstn), .cs_n_pin(cs_n_pin), .io_oe(io_oe),
    .quad_lines_enable(quad_lines_enable), .wrap_load(wrap_load),
    .wrap_settings(wrap_settings), .mem_addr(mem_addr),
    .skip_armed(skip_armed), .read_active(read_active),
    .wrap_state(wrap_state)
);

`default_nettype wire

// ==== sim/sfr_host.sv ====
// Host controller model: drives serial clock, select and data lines.
// Assumes tasks are entered just after a sys_clk rising edge.
`default_nettype none

module sfr_host (
    input wire logic sys_clk,
    output logic sclk,
    output logic cs_n,
    output logic [3:0] io_w,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] io_h = 4'h0;
    logic [3:0] he = 4'h0;
    logic [3:0] last_r = 4'h0;
    logic [3:0] s;
    logic so;
    initial sclk = 1'b0;
    initial cs_n = 1'b1;
    // Undriven lines toggle so stale data never reads as valid
    assign io_w = (io_oe & io_out) | (~io_oe & he & io_h)
        | (~io_oe & ~he & ~last_r);
    always_ff @(posedge sys_clk) last_r <= io_w;
    task automatic w(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic c(input logic [3:0] v, input logic [3:0] en);
        io_h <= v;
        he <= en;
        w(4);
        sclk <= 1'b1;
        w(3);
        he <= 4'h0;
        @(negedge sys_clk);
        s = io_w;
        so = |io_oe;
        w(1);
        sclk <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] op, input int wd, input bit skp,
        input bit fl, input logic [31:0] am, input int nd, input int nb,
        output logic [7:0] q [$], output bit dr);
        logic [3:0] mk;
        logic [15:0] acc;
        mk = wd == 4 ? 4'hf : 4'h3;
        q = {};
        dr = 1'b0;
        acc = 16'h0;
        cs_n <= 1'b0;
        w(4);
        if (!skp && fl) begin
            c(op[7:4], 4'hf);
            c(op[3:0], 4'hf);
        end else if (!skp) begin
            for (int i = 7; i >= 0; i--) c({3'h0, op[i]}, 4'h1);
        end
        for (int i = 32 - wd; i >= 0; i -= wd) begin
            c(4'(am >> i) & mk, mk);
        end
        for (int i = 0; i < nd; i++) c(4'($urandom), 4'hf);
        for (int i = 0; i < nb * 8 / wd; i++) begin
            c(4'h0, 4'h0);
            dr |= so;
            acc = (acc << wd) | 16'(s & mk);
            if ((i + 1) % (8 / wd) == 0) q.push_back(acc[7:0]);
        end
        w(2);
        cs_n <= 1'b1;
        w(8);
    endtask
endmodule

`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench for the multi-line read sequencer.
// Assumes sfr_host as far side and a combinational array model.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sfr_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic quad_en = 1'b0;
    logic fl_mode = 1'b0;
    logic wrap_ld = 1'b0;
    logic [2:0] wrap_v = 3'h1;
    logic par_ld = 1'b0;
    logic [1:0] par_v = 2'h0;
    logic rst_cmd = 1'b0;
    logic sclk, cs_n, skip_armed, read_active;
    logic [3:0] io_w, io_out, io_oe;
    logic [23:0] mem_addr;
    logic [7:0] mem_rdata;
    logic [2:0] wrap_state;
    logic [2:0] ws = 3'h1;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    always #5 sys_clk = ~sys_clk;
    sfr_host u_sfr_host (.sys_clk(sys_clk), .sclk(sclk), .cs_n(cs_n),
        .io_w(io_w), .io_out(io_out), .io_oe(io_oe));
    sfr_multi_io_read u_sfr_multi_io_read (.sys_clk(sys_clk), .rstn(rstn),
        .sclk_pin(sclk), .cs_n_pin(cs_n), .io_in(io_w), .io_out(io_out),
        .io_oe(io_oe), .quad_lines_enable(quad_en),
        .four_line_command_mode(fl_mode), .wrap_load(wrap_ld),
        .wrap_settings(wrap_v), .read_param_load(par_ld),
        .read_param_dummy(par_v), .reset_cmd(rst_cmd),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .skip_armed(skip_armed), .read_active(read_active),
        .wrap_state(wrap_state));
    function automatic logic [7:0] memf(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3c;
    endfunction
    assign mem_rdata = memf(mem_addr);
    function automatic logic [23:0] nxt(input logic [23:0] a,
        input bit wr, input logic [1:0] ln);
        logic [23:0] sz;
        sz = 24'h8 << ln;
        return wr ? (a & ~(sz - 24'h1)) | ((a + 24'h1) & (sz - 24'h1))
            : a + 24'h1;
    endfunction
    function automatic logic [23:0] ra();
        return 24'($urandom);
    endfunction
    function automatic logic [7:0] arm();
        return {2'($urandom), 2'h2, 4'($urandom)};
    endfunction
    ////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic rdchk(input logic [7:0] op, input bit qd,
        input bit skp, input logic [23:0] a, input logic [7:0] m,
        input int nd, input int nb);
        logic [7:0] got [$];
        bit dr;
        u_sfr_host.rd(op, qd ? 4 : 2, skp, fl_mode, {a, m}, nd, nb, got, dr);
        for (int i = 0; i < nb; i++) begin
            chk(got[i], memf(a));
            a = nxt(a, qd & !ws[0], ws[2:1]);
        end
        chk(skip_armed, m[5:4] == 2'h2);
        chk(read_active, 1'b0);
        chk(io_oe, 4'h0);
    endtask
    task automatic set_wrap(input logic [2:0] v);
        ws = v;
        wrap_v <= v;
        wrap_ld <= 1'b1;
        @(posedge sys_clk);
        wrap_ld <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(wrap_state, v);
    endtask
    task automatic pulse(input bit par, input logic [1:0] v);
        par_v <= v;
        par_ld <= par;
        rst_cmd <= !par;
        @(posedge sys_clk);
        par_ld <= 1'b0;
        rst_cmd <= 1'b0;
        @(posedge sys_clk);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] got [$];
        bit dr;
        logic [23:0] a;
        void'($urandom(32'h4a22_9838));
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (5) @(posedge sys_clk);
        chk(wrap_state, 3'h1);
        rdchk(8'hbb, 0, 0, ra(), arm(), 0, 4);
        rdchk(8'hbb, 0, 1, ra(), arm(), 0, 3);
        rdchk(8'hbb, 0, 1, ra() | 24'h55_5555, 8'h55, 0, 2);
        rdchk(8'hbb, 0, 0, ra(), 8'($urandom) | 8'h10, 0, 2);
        u_sfr_host.rd(8'heb, 4, 0, 0, 32'($urandom), 4, 2, got, dr);
        chk(dr, 1'b0);
        quad_en <= 1'b1;
        for (int l = 0; l < 4; l++) begin
            set_wrap({2'(l), 1'b0});
            a = (ra() | ((24'h8 << l) - 24'h1)) - 24'h1;
            rdchk(8'heb, 1, 0, a, 8'h10, 4, (8 << l) + 2);
        end
        set_wrap(3'h2);
        rdchk(8'he7, 1, 0, ra() & 24'hff_fffe, arm(), 2, 18);
        rdchk(8'he7, 1, 1, ra() & 24'hff_fffe, 8'h20, 2, 4);
        set_wrap(3'h7);
        rdchk(8'heb, 1, 1, ra() | 24'h00_00fe, 8'h10, 2, 4);
        fl_mode <= 1'b1;
        set_wrap(3'h4);
        for (int p = 0; p < 4; p++) begin
            pulse(1, 2'(p));
            rdchk(8'heb, 1, 0, ra(), p == 3 ? arm() : 8'h10,
                2 * p + 2, 6);
        end
        rdchk(8'heb, 1, 1, ra(), arm(), 8, 5);
        rdchk(8'heb, 1, 1, ra() | 24'h11_1111, 8'hff, 8, 3);
        pulse(0, 2'h3);
        rdchk(8'heb, 1, 0, ra(), 8'h10, 2, 3);
        u_sfr_host.rd(8'hbb, 2, 0, 1, 32'($urandom), 0, 2, got, dr);
        chk(dr, 1'b0);
        report_and_stop();
    end
endmodule

`default_nettype wire
